/* hw/rsp_pkg.sv */
package rsp_pkg;

  // Register word indices; the byte address is four times the index.
  localparam logic [7:0] RSP_IDX_CTL = 8'h03;
  localparam logic [7:0] RSP_IDX_STAT = 8'h04;
  localparam int RSP_ADDR_W = 8;
  localparam logic [RSP_ADDR_W-1:0] RSP_ADDR_CTL = RSP_ADDR_W'(RSP_IDX_CTL * 4);
  localparam logic [RSP_ADDR_W-1:0] RSP_ADDR_STAT = RSP_ADDR_W'(RSP_IDX_STAT * 4);

  // Control register layout.
  localparam int RSP_CTL_W = 24;
  localparam logic [RSP_CTL_W-1:0] RSP_CTL_RESET = 24'h000000;
  localparam logic [RSP_CTL_W-1:0] RSP_CTL_WMASK = 24'h01FFFF;
  localparam int RSP_B_EN = 0;
  localparam int RSP_B_FREQ = 1;
  localparam int RSP_B_AMP = 3;
  localparam int RSP_B_LEAD = 5;
  localparam int RSP_B_EXTSEL = 7;
  localparam int RSP_B_GAIN = 8;
  localparam int RSP_B_CAP = 12;
  localparam int RSP_B_OUT = 13;
  localparam int RSP_B_BYPASS = 14;
  localparam int RSP_B_SYNC = 15;
  localparam int RSP_B_PERIODIC = 16;

  // Lead codes.
  localparam logic [1:0] RSP_LEAD_EXT = 2'h3;

  // Gain saturation point: code 1001 gives x10.
  localparam logic [3:0] RSP_GAIN_MAX_CODE = 4'h9;

  // Carrier timing.
  localparam int RSP_CLK_HZ = 100_000_000;
  localparam int RSP_HALF_W = 12;
  localparam int RSP_SKIP_N = 16;
  localparam int RSP_DAC_W = 8;
  localparam logic [RSP_DAC_W-1:0] RSP_DAC_MID = 8'h80;
  localparam logic [RSP_DAC_W-1:0] RSP_DAC_SPAN = 8'h7F;

  // AXI response codes.
  localparam logic [1:0] RSP_RESP_OKAY = 2'h0;
  localparam logic [1:0] RSP_RESP_SLVERR = 2'h2;

  // Carrier frequencies in Hz, per frequency code, for each mode.
  function automatic int rsp_freq_hz(input logic periodic, input logic [1:0] code);
    int tab_gap [4];
    int tab_per [4];
    tab_gap = '{56000, 54000, 52000, 50000};
    tab_per = '{64000, 56900, 51200, 46500};
    return periodic ? tab_per[code] : tab_gap[code];
  endfunction

  // Clock cycles in half a carrier period.
  function automatic logic [RSP_HALF_W-1:0] rsp_half_count(input logic periodic,
                                                           input logic [1:0] code);
    return RSP_HALF_W'(RSP_CLK_HZ / (2 * rsp_freq_hz(periodic, code)));
  endfunction

  // Amplifier gain: code plus one, saturating at ten.
  function automatic logic [3:0] rsp_gain(input logic [3:0] code);
    return (code > RSP_GAIN_MAX_CODE) ? 4'hA : 4'(code + 4'h1);
  endfunction

endpackage

/* hw/rsp_carrier_gen.sv */
`timescale 1ns/1ps
module rsp_carrier_gen
  import rsp_pkg::*;
#(
  parameter int SKIP_N = RSP_SKIP_N
)(
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic enable, // Measurement enable.
  input wire logic periodic, // Constant-period mode.
  input wire logic [1:0] freq_code, // Frequency code.
  input wire logic [1:0] amp_code, // Tone amplitude code.
  output logic [RSP_DAC_W-1:0] dac_code, // Carrier DAC code.
  output logic dac_msb, // Carrier DAC most significant bit.
  output logic [7:0] cycle_count // Completed carrier cycles.
);

  logic [RSP_HALF_W-1:0] cnt;
  logic [RSP_HALF_W-1:0] next_cnt;
  logic phase;
  logic next_phase;
  logic [7:0] next_cycle_count;
  logic [$clog2(SKIP_N+1)-1:0] gap;
  logic [$clog2(SKIP_N+1)-1:0] next_gap;
  logic [RSP_DAC_W-1:0] next_dac_code;
  logic [RSP_HALF_W-1:0] limit;
  logic [RSP_DAC_W-1:0] swing;

  // In gap mode every SKIP_N-th cycle is stretched by one clock, so the period is not constant.
  always_comb
  begin
    limit = rsp_half_count(periodic, freq_code); // R11
    if (!periodic && gap == ($bits(gap))'(SKIP_N - 1) && phase)
    begin
      limit = RSP_HALF_W'(limit + 1'b1); // R01
    end
    swing = RSP_DAC_SPAN >> (2'h3 - amp_code); // R10
    next_cnt = cnt;
    next_phase = phase;
    next_gap = gap;
    next_cycle_count = cycle_count;
    if (!enable)
    begin
      next_cnt = '0;
      next_phase = 1'b0;
      next_gap = '0;
    end
    else if (cnt + 1'b1 >= limit)
    begin
      next_cnt = '0;
      next_phase = !phase;
      if (phase)
      begin
        next_cycle_count = 8'(cycle_count + 8'h01);
        next_gap = (gap == ($bits(gap))'(SKIP_N - 1)) ? '0 : ($bits(gap))'(gap + 1'b1);
      end
    end
    else
    begin
      next_cnt = RSP_HALF_W'(cnt + 1'b1);
    end
    if (!enable)
    begin
      next_dac_code = RSP_DAC_MID;
    end
    else
    begin
      next_dac_code = next_phase ? RSP_DAC_W'(RSP_DAC_MID + swing) : RSP_DAC_W'(RSP_DAC_MID - swing);
    end
  end

  // Registers only.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt <= '0;
      phase <= 1'b0;
      gap <= '0;
      cycle_count <= 8'h00;
      dac_code <= RSP_DAC_MID;
    end
    else
    begin
      cnt <= next_cnt;
      phase <= next_phase;
      gap <= next_gap;
      cycle_count <= next_cycle_count;
      dac_code <= next_dac_code;
    end
  end

  // The MSB of the DAC code is high on the upper half-cycle.
  assign dac_msb = dac_code[RSP_DAC_W-1];

endmodule

/* hw/rsp_path_select.sv */
`timescale 1ns/1ps
module rsp_path_select
  import rsp_pkg::*;
(
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [RSP_CTL_W-1:0] ctl, // Control register value.
  output logic [3:0] amp_gain, // Amplifier gain, 1 to 10.
  output logic amp_bypass, // On-chip amplifier bypassed to ADC.
  output logic cap_external, // External capacitors selected.
  output logic drive_right_arm, // Drive on right-arm DAC, else left leg.
  output logic [1:0] lead_select, // Lead: I, II, III or external.
  output logic ext_path_active, // External respiration path in use.
  output logic ext_path_right_arm // External input path choice.
);

  logic [9:0] next_sel;

  // Decode the analog switch settings from the register fields.
  always_comb
  begin
    next_sel[3:0] = rsp_gain(ctl[RSP_B_GAIN +: 4]); // R07
    next_sel[4] = ctl[RSP_B_BYPASS]; // R04
    next_sel[5] = ctl[RSP_B_CAP]; // R06
    next_sel[6] = ctl[RSP_B_OUT] | ctl[RSP_B_CAP]; // R05
    next_sel[8:7] = ctl[RSP_B_LEAD +: 2]; // R09
    next_sel[9] = 1'b0;
    if (ctl[RSP_B_LEAD +: 2] == RSP_LEAD_EXT)
    begin
      next_sel[9] = ctl[RSP_B_EXTSEL]; // R08
    end
  end

  // Switch controls except ext_path_active come from flip-flops so they never glitch.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      amp_gain <= 4'h1;
      amp_bypass <= 1'b0;
      cap_external <= 1'b0;
      drive_right_arm <= 1'b0;
      lead_select <= 2'h0;
      ext_path_right_arm <= 1'b0;
    end
    else
    begin
      amp_gain <= next_sel[3:0];
      amp_bypass <= next_sel[4];
      cap_external <= next_sel[5];
      drive_right_arm <= next_sel[6];
      lead_select <= next_sel[8:7];
      ext_path_right_arm <= next_sel[9];
    end
  end

  assign ext_path_active = (lead_select == RSP_LEAD_EXT);

endmodule

/* hw/rsp_ctl_top.sv */
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
//
// Contract
// R01 - Gap mode stretches carrier; periodic mode steady.
// R02 - Sync bit drives DAC MSB onto pin three.
// R03 - Sync period constant only in periodic mode.
// R04 - Bypass bit routes input straight to ADC.
// R05 - Drive select; capacitor bit forces right arm.
// R06 - Capacitor bit chooses internal or external.
// R07 - Gain is code plus one, saturating ten.
// R08 - External path select only for external lead.
// R09 - Lead field picks I, II, III, external.
// R10 - Amplitude field scales tone eighth to full.
// R11 - Frequency field and mode set carrier rate.
// R12 - Enable bit starts measurement, off at reset.
// R13 - Software writes zero to reserved top bits.
module rsp_ctl_top
  import rsp_pkg::*;
#(
  parameter int SKIP_N = RSP_SKIP_N
)(
  input wire logic aclk, // System clock, 100 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [RSP_ADDR_W-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [RSP_ADDR_W-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic gpio_three_out, // Normal pin-three output level.
  input wire logic gpio_three_oe, // Normal pin-three output enable.
  output logic general_pin_three_o, // Pin-three output level.
  output logic general_pin_three_oe, // Pin-three output enable.
  output logic [RSP_DAC_W-1:0] carrier_dac_left_leg, // Left-leg carrier DAC code.
  output logic [RSP_DAC_W-1:0] carrier_dac_right_arm, // Right-arm carrier DAC code.
  output logic measurement_active, // Respiration measurement running.
  output logic [3:0] amp_gain, // Amplifier gain, 1 to 10.
  output logic external_amp_bypass, // On-chip amplifier bypassed.
  output logic capacitor_external, // External capacitors in use.
  output logic [1:0] lead_select, // Selected respiration lead.
  output logic external_path_active, // External path in use.
  output logic external_input_right_arm // External input path choice.
);

  typedef enum logic [1:0] {
    RSP_W_IDLE = 2'b00,
    RSP_W_ADDR = 2'b01,
    RSP_W_RESP = 2'b11,
    RSP_W_DATA = 2'b10
  } rsp_wstate_t;

  typedef enum logic {
    RSP_R_IDLE = 1'b0,
    RSP_R_DATA = 1'b1
  } rsp_rstate_t;

  rsp_wstate_t wstate;
  rsp_wstate_t next_wstate;
  rsp_rstate_t rstate;
  rsp_rstate_t next_rstate;
  logic [RSP_ADDR_W-1:0] waddr;
  logic [RSP_ADDR_W-1:0] next_waddr;
  logic [31:0] wdata;
  logic [31:0] next_wdata;
  logic [3:0] wstrb;
  logic [3:0] next_wstrb;
  logic [1:0] next_bresp;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [RSP_CTL_W-1:0] respiration_control;
  logic [RSP_CTL_W-1:0] next_respiration_control;
  logic aw_take;
  logic w_take;
  logic do_write;
  logic [RSP_ADDR_W-1:0] cur_waddr;
  logic [31:0] cur_wdata;
  logic [3:0] cur_wstrb;
  logic [RSP_DAC_W-1:0] dac_code;
  logic dac_msb;
  logic [7:0] cycle_count;
  logic drive_right_arm;
  logic [RSP_DAC_W-1:0] next_dac_ll;
  logic [RSP_DAC_W-1:0] next_dac_ra;
  logic next_pin_o;
  logic next_pin_oe;

  // Merge the write strobes into a byte mask over the implemented width.
  function automatic logic [RSP_CTL_W-1:0] strb_mask(input logic [3:0] strb);
    return {{8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // Address and data may arrive in either order; each is held until the other shows.
  assign s_axi_awready = (wstate == RSP_W_IDLE) || (wstate == RSP_W_DATA);
  assign s_axi_wready = (wstate == RSP_W_IDLE) || (wstate == RSP_W_ADDR);
  assign s_axi_bvalid = (wstate == RSP_W_RESP);
  assign s_axi_arready = (rstate == RSP_R_IDLE);
  assign s_axi_rvalid = (rstate == RSP_R_DATA);
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;

  // Write channel sequencing and register update.
  always_comb
  begin
    next_wstate = wstate;
    next_waddr = waddr;
    next_wdata = wdata;
    next_wstrb = wstrb;
    next_bresp = s_axi_bresp;
    cur_waddr = aw_take ? s_axi_awaddr : waddr;
    cur_wdata = w_take ? s_axi_wdata : wdata;
    cur_wstrb = w_take ? s_axi_wstrb : wstrb;
    do_write = 1'b0;
    if (aw_take)
    begin
      next_waddr = s_axi_awaddr;
    end
    if (w_take)
    begin
      next_wdata = s_axi_wdata;
      next_wstrb = s_axi_wstrb;
    end
    case (wstate)
      RSP_W_IDLE:
      begin
        if (aw_take && w_take)
        begin
          do_write = 1'b1;
        end
        else if (aw_take)
        begin
          next_wstate = RSP_W_ADDR;
        end
        else if (w_take)
        begin
          next_wstate = RSP_W_DATA;
        end
      end
      RSP_W_ADDR:
      begin
        do_write = w_take;
      end
      RSP_W_DATA:
      begin
        do_write = aw_take;
      end
      default:
      begin
        if (s_axi_bready)
        begin
          next_wstate = RSP_W_IDLE;
        end
      end
    endcase
    next_respiration_control = respiration_control;
    if (do_write)
    begin
      next_wstate = RSP_W_RESP;
      next_bresp = RSP_RESP_SLVERR;
      if (cur_waddr == RSP_ADDR_CTL)
      begin
        // Reserved bits 23:17 are not stored; software is expected to write them as zero.
        next_respiration_control = (respiration_control & ~strb_mask(cur_wstrb)) |
          (cur_wdata[RSP_CTL_W-1:0] & strb_mask(cur_wstrb) & RSP_CTL_WMASK); // R13
        next_bresp = RSP_RESP_OKAY;
      end
      else if (cur_waddr == RSP_ADDR_STAT)
      begin
        next_bresp = RSP_RESP_SLVERR;
      end
    end
  end

  // Read channel: one cycle from address to data.
  always_comb
  begin
    next_rstate = rstate;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (rstate == RSP_R_IDLE)
    begin
      if (s_axi_arvalid)
      begin
        next_rstate = RSP_R_DATA;
        next_rdata = 32'h00000000;
        next_rresp = RSP_RESP_OKAY;
        if (s_axi_araddr == RSP_ADDR_CTL)
        begin
          next_rdata = {8'h00, respiration_control};
        end
        else if (s_axi_araddr == RSP_ADDR_STAT)
        begin
          next_rdata = {16'h0000, cycle_count, 5'h00, drive_right_arm, dac_msb,
                        measurement_active};
        end
        else
        begin
          next_rresp = RSP_RESP_SLVERR;
        end
      end
    end
    else if (s_axi_rready)
    begin
      next_rstate = RSP_R_IDLE;
    end
  end

  // Bus state registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wstate <= RSP_W_IDLE;
      rstate <= RSP_R_IDLE;
      waddr <= '0;
      wdata <= 32'h00000000;
      wstrb <= 4'h0;
      s_axi_bresp <= RSP_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RSP_RESP_OKAY;
      respiration_control <= RSP_CTL_RESET;
    end
    else
    begin
      wstate <= next_wstate;
      rstate <= next_rstate;
      waddr <= next_waddr;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      s_axi_bresp <= next_bresp;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      respiration_control <= next_respiration_control;
    end
  end

  assign measurement_active = respiration_control[RSP_B_EN]; // R12

  // Carrier generator; its period is steady only in periodic mode.
  rsp_carrier_gen #(
    .SKIP_N(SKIP_N)
  ) u_carrier (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(respiration_control[RSP_B_EN]), // R12
    .periodic(respiration_control[RSP_B_PERIODIC]), // R01
    .freq_code(respiration_control[RSP_B_FREQ +: 2]), // R11
    .amp_code(respiration_control[RSP_B_AMP +: 2]), // R10
    .dac_code(dac_code),
    .dac_msb(dac_msb),
    .cycle_count(cycle_count)
  );

  // Analog path switch decode.
  rsp_path_select u_path (
    .aclk(aclk),
    .aresetn(aresetn),
    .ctl(respiration_control),
    .amp_gain(amp_gain),
    .amp_bypass(external_amp_bypass),
    .cap_external(capacitor_external),
    .drive_right_arm(drive_right_arm),
    .lead_select(lead_select),
    .ext_path_active(external_path_active),
    .ext_path_right_arm(external_input_right_arm)
  );

  // Route the carrier to one drive DAC and the MSB to pin three when asked.
  always_comb
  begin
    next_dac_ll = drive_right_arm ? RSP_DAC_MID : dac_code; // R05
    next_dac_ra = drive_right_arm ? dac_code : RSP_DAC_MID; // R05
    next_pin_o = gpio_three_out;
    next_pin_oe = gpio_three_oe;
    if (respiration_control[RSP_B_SYNC])
    begin
      // Steady sync needs periodic mode; gap mode still passes the MSB as it is.
      next_pin_o = dac_msb; // R02 R03
      next_pin_oe = 1'b1; // R02
    end
  end

  // The unused DAC rests at mid-scale so it injects no carrier.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      carrier_dac_left_leg <= RSP_DAC_MID;
      carrier_dac_right_arm <= RSP_DAC_MID;
      general_pin_three_o <= 1'b0;
      general_pin_three_oe <= 1'b0;
    end
    else
    begin
      carrier_dac_left_leg <= next_dac_ll;
      carrier_dac_right_arm <= next_dac_ra;
      general_pin_three_o <= next_pin_o;
      general_pin_three_oe <= next_pin_oe;
    end
  end

endmodule

/* tb/rsp_ctl_checker.sv */
`timescale 1ns/1ps
module rsp_ctl_checker
  import rsp_pkg::*;
#(
  parameter int SKIP_N = RSP_SKIP_N
)(
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset.
  input wire logic s_axi_awvalid, // Aw valid.
  input wire logic s_axi_awready, // Aw ready.
  input wire logic s_axi_wvalid, // W valid.
  input wire logic s_axi_wready, // W ready.
  input wire logic [1:0] s_axi_bresp, // B code.
  input wire logic s_axi_bvalid, // B valid.
  input wire logic s_axi_bready, // B ready.
  input wire logic s_axi_arvalid, // Ar valid.
  input wire logic s_axi_arready, // Ar ready.
  input wire logic [31:0] s_axi_rdata, // R data.
  input wire logic s_axi_rvalid, // R valid.
  input wire logic s_axi_rready, // R ready.
  input wire logic [RSP_DAC_W-1:0] carrier_dac_left_leg, // Left DAC.
  input wire logic [RSP_DAC_W-1:0] carrier_dac_right_arm, // Right DAC.
  input wire logic measurement_active, // Enable.
  input wire logic [3:0] amp_gain, // Gain.
  input wire logic capacitor_external, // Cap source.
  input wire logic [1:0] lead_select, // Lead.
  input wire logic external_path_active, // Ext path.
  input wire logic external_input_right_arm // Ext choice.
);
  // All checks share the one clock and its reset.
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_wr_answer; s_wr_taken |=> s_axi_bvalid; endproperty
  property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  // The first edge after reset may still show the reset gain, so it is skipped.
  property p_gain; $past(aresetn) |-> amp_gain >= 4'h1 && amp_gain <= 4'hA; endproperty
  property p_ext_path; external_path_active == (lead_select == RSP_LEAD_EXT); endproperty
  property p_ext_sel; !external_path_active |-> !external_input_right_arm; endproperty
  // Three cycles cover the register and DAC output lags.
  property p_cap_left; capacitor_external [*3] |-> carrier_dac_left_leg == RSP_DAC_MID;
  endproperty
  property p_idle; !measurement_active [*3] |->
    carrier_dac_left_leg == RSP_DAC_MID && carrier_dac_right_arm == RSP_DAC_MID;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_gain: assert property (p_gain) else $error("gain out of range");
  a_ext_path: assert property (p_ext_path) else $error("ext path flag wrong");
  a_ext_sel: assert property (p_ext_sel) else $error("ext choice leaks");
  a_cap_left: assert property (p_cap_left) else $error("left leg driven");
  a_idle: assert property (p_idle) else $error("carrier runs while off");
endmodule

bind rsp_ctl_top rsp_ctl_checker #(.SKIP_N(SKIP_N)) chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .carrier_dac_left_leg(carrier_dac_left_leg), .carrier_dac_right_arm(carrier_dac_right_arm),
  .measurement_active(measurement_active), .amp_gain(amp_gain),
  .capacitor_external(capacitor_external), .lead_select(lead_select),
  .external_path_active(external_path_active),
  .external_input_right_arm(external_input_right_arm));

/* tb/rsp_gpio_model.sv */
`timescale 1ns/1ps
module rsp_gpio_model (
  input wire logic aclk, // Clock.
  output logic gpio_three_out, // Pin level.
  output logic gpio_three_oe // Pin enable.
);
  logic [1:0] cnt = 2'h0;
  // Level and enable change at different rates so a swapped route shows.
  always_ff @(posedge aclk) cnt <= cnt + 2'h1;
  assign gpio_three_out = cnt[0];
  assign gpio_three_oe = cnt[1];
endmodule

/* tb/respiration_control_register_bench.sv */
`timescale 1ns/1ps
module respiration_control_register_bench;
  import rsp_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'h0, amp_gain;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, gpio_three_out, gpio_three_oe;
  logic general_pin_three_o, general_pin_three_oe, measurement_active, capacitor_external;
  logic external_amp_bypass, external_path_active, external_input_right_arm, q, qe;
  logic [1:0] s_axi_bresp, s_axi_rresp, lead_select, r;
  logic [7:0] carrier_dac_left_leg, carrier_dac_right_arm, mx;
  int miscompares = 0, num_checks = 0, p1, p2, p3;
  int fp [4] = '{64000, 56900, 51200, 46500};
  always #5 aclk = ~aclk;
  rsp_gpio_model gpio_u (.aclk(aclk), .gpio_three_out(gpio_three_out),
    .gpio_three_oe(gpio_three_oe));
  // Gap mode stretch shortened so the uneven period shows within few cycles.
  rsp_ctl_top #(.SKIP_N(2)) dut_u (.*);
  task close_out;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      $display("mismatch %0t %s", $time, m);
      miscompares++;
    end
  endtask
  task hang;
    miscompares++;
    $display("mismatch %0t wait ran out", $time);
    close_out();
  endtask
  // Handshakes are judged at the falling edge, where the edge ahead will take them.
  task wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 40 && !tb; n++)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      s_axi_bready <= !tb && n > 0;
    end
    if (!tb) hang();
  endtask
  task rd(input logic [7:0] a);
    logic ta, tr;
    tr = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 40 && !tr; n++)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      s_axi_rready <= !tr && n > 0;
    end
    if (!tr) hang();
  endtask
  task rise;
    int n;
    q = 1'b1;
    for (n = 0; n < 3000; n++)
    begin
      @(negedge aclk);
      if (q === 1'b0 && general_pin_three_o === 1'b1) break;
      q = general_pin_three_o;
    end
    if (n == 3000) hang();
  endtask
  // Measures from the call to the next rise, so back-to-back calls give consecutive periods.
  // Skipping a period between samples would hide a stretch that comes every second cycle.
  // The first call after a setting change only lines the measurement up on an edge.
  task per(output int p);
    realtime t;
    t = $realtime;
    rise();
    p = int'(($realtime - t) / 10.0);
  endtask
  // Main sequence: defaults, bus edges, field decode, tone and carrier timing.
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(RSP_ADDR_CTL);
    chk(d, 32'h0, "reset value");
    @(negedge aclk);
    q = gpio_three_out;
    qe = gpio_three_oe;
    @(negedge aclk);
    chk({general_pin_three_o, general_pin_three_oe}, {q, qe}, "pin normal use");
    wr(RSP_ADDR_CTL, 32'hFFFFFFFF, 4'hF);
    chk(r, RSP_RESP_OKAY, "write code");
    rd(RSP_ADDR_CTL);
    chk(d, 32'h0001FFFF, "reserved bits");
    wr(RSP_ADDR_CTL, 32'h0, 4'hF);
    wr(RSP_ADDR_CTL, 32'hFFFFFFFF, 4'h2);
    rd(RSP_ADDR_CTL);
    chk(d, 32'h0000FF00, "byte strobe");
    wr(8'h40, 32'h1, 4'hF);
    chk(r, RSP_RESP_SLVERR, "unmapped write");
    wr(RSP_ADDR_STAT, 32'h1, 4'hF);
    chk(r, RSP_RESP_SLVERR, "status write");
    rd(8'h40);
    chk(d, 32'h0, "unmapped read data");
    chk(r, RSP_RESP_SLVERR, "unmapped read code");
    for (int c = 0; c < 16; c++)
    begin
      wr(RSP_ADDR_CTL, (c << 8) | ((c & 3) << 5) | ((c & 4) << 10) | ((c & 8) << 10)
        | ((c & 1) << 14) | 32'h99, 4'hF);
      repeat (4) @(negedge aclk);
      chk(32'(amp_gain), (c > 9) ? 10 : c + 1, "gain");
      chk(32'(lead_select), c & 3, "lead");
      chk(32'(external_input_right_arm), 32'((c & 3) == 3), "ext choice");
      chk(32'(capacitor_external), (c >> 2) & 1, "cap source");
      chk(32'(external_amp_bypass), c & 1, "bypass");
      chk(32'(measurement_active), 1, "enable");
      if (c & 12) chk(32'(carrier_dac_left_leg), 32'h80, "left idle");
      else chk(32'(carrier_dac_right_arm), 32'h80, "right idle");
      rd(RSP_ADDR_STAT);
      chk(d & 5, 32'((c & 12) != 0) * 4 + 1, "status drive");
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(RSP_ADDR_CTL, 32'h10001 | (k << 3), 4'hF);
      mx = 8'h00;
      repeat (1600) @(negedge aclk) if (carrier_dac_left_leg > mx) mx = carrier_dac_left_leg;
      chk(32'(mx), RSP_DAC_MID + (RSP_DAC_SPAN >> (3 - k)), "tone amplitude");
    end
    for (int f = 0; f < 4; f++)
    begin
      wr(RSP_ADDR_CTL, 32'h18001 | (f << 1), 4'hF);
      per(p1);
      per(p1);
      per(p2);
      chk(p1, 2 * (RSP_CLK_HZ / (2 * fp[f])), "periodic rate");
      chk(p2, p1, "steady sync");
      chk(32'(general_pin_three_oe), 1, "sync drives pin");
    end
    wr(RSP_ADDR_CTL, 32'h08007, 4'hF);
    per(p1);
    per(p1);
    per(p2);
    per(p3);
    chk(32'(p1 != p2 || p2 != p3), 1, "gap mode stretch");
    chk(32'(p1 >= 2000 && p1 <= 2001), 1, "gap rate");
    wr(RSP_ADDR_CTL, 32'h0, 4'hF);
    repeat (4) @(negedge aclk);
    chk({carrier_dac_left_leg, carrier_dac_right_arm}, 16'h8080, "off idle");
    close_out();
  end
endmodule
